// *** shared/dcr_pkg.sv ***
// Constants, field codes and carrier types for the converter control register bank
package dcr_pkg;

	localparam int DCR_ADDR_W = 5;
	localparam int DCR_DATA_W = 16;
	localparam int DCR_FIELD_W = 2;

	// Register offsets in the x16 register map
	localparam logic [4:0] DCR_OFS_CODE_CH0 = 5'h00;
	localparam logic [4:0] DCR_OFS_CODE_CH1 = 5'h01;
	localparam logic [4:0] DCR_OFS_REF_SEL = 5'h08;
	localparam logic [4:0] DCR_OFS_PWR_DOWN = 5'h09;

	// Reset values of the select registers
	localparam logic [15:0] DCR_RST_REF_SEL = 16'h0000;
	localparam logic [15:0] DCR_RST_PWR_DOWN = 16'h0000;

	// Default resolution and channel count, and the largest channel count
	localparam int DCR_DEF_RES_BITS = 12;
	localparam int DCR_DEF_NUM_CH = 2;
	localparam int DCR_MAX_NUM_CH = 2;

	// Reference source field codes
	localparam logic [1:0] DCR_REF_VDD = 2'h0;
	localparam logic [1:0] DCR_REF_BANDGAP = 2'h1;
	localparam logic [1:0] DCR_REF_PIN_UNBUF = 2'h2;
	localparam logic [1:0] DCR_REF_PIN_BUF = 2'h3;

	// Power-down field codes
	localparam logic [1:0] DCR_PD_NORMAL = 2'h0;
	localparam logic [1:0] DCR_PD_LOAD_1K = 2'h1;
	localparam logic [1:0] DCR_PD_LOAD_100K = 2'h2;
	localparam logic [1:0] DCR_PD_OPEN = 2'h3;

	typedef enum logic [1:0] {
		DCR_SRC_VDD,
		DCR_SRC_BANDGAP,
		DCR_SRC_PIN
	} dcr_ref_src_type;

	typedef enum logic [1:0] {
		DCR_LOAD_NONE,
		DCR_LOAD_1K,
		DCR_LOAD_100K,
		DCR_LOAD_OPEN
	} dcr_out_load_type;

	// Decoded per-channel controls for the analog side
	typedef struct packed {
		dcr_ref_src_type ref_src;
		logic ref_buf_en;
		logic out_active;
		dcr_out_load_type out_load;
	} dcr_ch_ctl_type;

	// Register access request from the serial command engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [DCR_ADDR_W-1:0] addr;
		logic [DCR_DATA_W-1:0] wdata;
	} dcr_req_type;

	// Answer to one register access
	typedef struct packed {
		logic valid;
		logic err;
		logic [DCR_DATA_W-1:0] rdata;
	} dcr_rsp_type;

endpackage

// *** src/dcr_ch_decode.sv ***
// Per-channel decoder from reference and power-down fields to analog controls
`timescale 1ns/10ps
module dcr_ch_decode (
	// Register fields
	input wire logic [1:0] ref_source_field_i,
	input wire logic [1:0] pd_mode_field_i,
	// Decoded controls
	output dcr_pkg::dcr_ch_ctl_type ctl_o
);
	import dcr_pkg::*;

	always_comb begin
		ctl_o = '0;
		case (ref_source_field_i)
			DCR_REF_PIN_BUF: begin
				ctl_o.ref_src = DCR_SRC_PIN;
				ctl_o.ref_buf_en = 1'b1;
			end
			DCR_REF_PIN_UNBUF: begin
				ctl_o.ref_src = DCR_SRC_PIN;
				ctl_o.ref_buf_en = 1'b0;
			end
			DCR_REF_BANDGAP: begin
				// Buffer stays on so the bandgap still drives the pin when powered down
				ctl_o.ref_src = DCR_SRC_BANDGAP;
				ctl_o.ref_buf_en = 1'b1;
			end
			default: begin
				ctl_o.ref_src = DCR_SRC_VDD;
				ctl_o.ref_buf_en = 1'b0;
			end
		endcase
		case (pd_mode_field_i)
			DCR_PD_LOAD_1K: begin
				ctl_o.out_active = 1'b0;
				ctl_o.out_load = DCR_LOAD_1K;
			end
			DCR_PD_LOAD_100K: begin
				ctl_o.out_active = 1'b0;
				ctl_o.out_load = DCR_LOAD_100K;
			end
			DCR_PD_OPEN: begin
				ctl_o.out_active = 1'b0;
				ctl_o.out_load = DCR_LOAD_OPEN;
			end
			default: begin
				ctl_o.out_active = 1'b1;
				ctl_o.out_load = DCR_LOAD_NONE;
			end
		endcase
	end

endmodule

// *** src/dcr_reg_bank.sv ***
// Volatile output-code, reference-select and power-down registers of the converter
`timescale 1ns/10ps

// Behaviour
// - 12-bit parts hold code in bits 11..0; FFF full, 7FF mid, 0 zero.
// - 10-bit parts hold code in bits 9..0; 3FF full, 1FF mid, 0 zero.
// - 8-bit parts hold code in bits 7..0; FF full, 7F mid, 0 zero.
// - Code bits above the resolution ignore writes and read zero.
// - Reference select: channel 0 bits 1..0, channel 1 bits 3..2 when dual.
// - Reference codes: 11 pin buffered, 10 pin raw, 01 bandgap, 00 supply.
// - Select and power-down registers are twice the channel count wide.
// - Power-down: channel 0 bits 1..0, channel 1 bits 3..2 when dual.
// - Bits above the channel fields in both select registers read zero.
// - Power-down codes: 00 normal, 01 1k load, 10 100k load, 11 open.
module dcr_reg_bank #(
	parameter int RES_BITS = dcr_pkg::DCR_DEF_RES_BITS,
	parameter int NUM_CH = dcr_pkg::DCR_DEF_NUM_CH
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Register access from the serial command engine
	input dcr_pkg::dcr_req_type req_i,
	output dcr_pkg::dcr_rsp_type rsp_o,
	// Analog side controls
	output logic [NUM_CH-1:0][RES_BITS-1:0] ladder_code_o,
	output logic [2*NUM_CH-1:0] ref_sel_o,
	output logic [2*NUM_CH-1:0] pd_sel_o,
	output dcr_pkg::dcr_ch_ctl_type [NUM_CH-1:0] ch_ctl_o
);
	import dcr_pkg::*;

	localparam int SEL_W = DCR_FIELD_W * NUM_CH;
	localparam logic [RES_BITS-1:0] CODE_MID = {1'b0, {(RES_BITS-1){1'b1}}};
	localparam logic [RES_BITS-1:0] CODE_ONES = {RES_BITS{1'b1}};

	// Only the three documented resolutions and one or two channels exist
	if (!(RES_BITS == 8 || RES_BITS == 10 || RES_BITS == 12)) begin : g_bad_res
		$error("dcr_reg_bank: RES_BITS must be 8, 10 or 12");
	end
	if (NUM_CH < 1 || NUM_CH > DCR_MAX_NUM_CH) begin : g_bad_ch
		$error("dcr_reg_bank: NUM_CH must be 1 or 2");
	end

	// True for a location this part implements
	function automatic logic is_mapped(input logic [DCR_ADDR_W-1:0] addr);
		logic hit;
		hit = 1'b0;
		if (addr == DCR_OFS_CODE_CH0) begin
			hit = 1'b1;
		end else if (addr == DCR_OFS_CODE_CH1) begin
			hit = (NUM_CH > 1);
		end else if (addr == DCR_OFS_REF_SEL) begin
			hit = 1'b1;
		end else if (addr == DCR_OFS_PWR_DOWN) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	logic [NUM_CH-1:0][RES_BITS-1:0] code_q;
	logic [NUM_CH-1:0][RES_BITS-1:0] code_d;
	logic [SEL_W-1:0] ref_sel_q;
	logic [SEL_W-1:0] ref_sel_d;
	logic [SEL_W-1:0] pd_sel_q;
	logic [SEL_W-1:0] pd_sel_d;
	dcr_rsp_type rsp_q;
	dcr_rsp_type rsp_d;
	dcr_ch_ctl_type [NUM_CH-1:0] ctl_q;
	dcr_ch_ctl_type [NUM_CH-1:0] ctl_d;
	logic acc_ok;

	assign acc_ok = is_mapped(req_i.addr);

	// Register writes
	always_comb begin
		code_d = code_q;
		ref_sel_d = ref_sel_q;
		pd_sel_d = pd_sel_q;
		if (req_i.wr && acc_ok) begin
			if (req_i.addr == DCR_OFS_CODE_CH0) begin
				// Upper bits are simply not stored
				code_d[0] = req_i.wdata[RES_BITS-1:0];
			end else if (req_i.addr == DCR_OFS_CODE_CH1) begin
				code_d[NUM_CH-1] = req_i.wdata[RES_BITS-1:0];
			end else if (req_i.addr == DCR_OFS_REF_SEL) begin
				ref_sel_d = req_i.wdata[SEL_W-1:0];
			end else if (req_i.addr == DCR_OFS_PWR_DOWN) begin
				pd_sel_d = req_i.wdata[SEL_W-1:0];
			end
		end
	end

	// Read answer, one cycle after the request
	always_comb begin
		rsp_d = '0;
		if (req_i.wr || req_i.rd) begin
			rsp_d.valid = 1'b1;
			rsp_d.err = !acc_ok;
			if (req_i.rd) begin
				if (!acc_ok) begin
					// Reserved locations return ones across the code width
					rsp_d.rdata = DCR_DATA_W'(CODE_ONES);
				end else if (req_i.addr == DCR_OFS_CODE_CH0) begin
					rsp_d.rdata = DCR_DATA_W'(code_q[0]);
				end else if (req_i.addr == DCR_OFS_CODE_CH1) begin
					rsp_d.rdata = DCR_DATA_W'(code_q[NUM_CH-1]);
				end else if (req_i.addr == DCR_OFS_REF_SEL) begin
					rsp_d.rdata = DCR_DATA_W'(ref_sel_q);
				end else begin
					rsp_d.rdata = DCR_DATA_W'(pd_sel_q);
				end
			end
		end
	end

	// Per-channel decode into analog controls
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		dcr_ch_decode u_decode (
			.ref_source_field_i(ref_sel_q[DCR_FIELD_W*ch +: DCR_FIELD_W]),
			.pd_mode_field_i(pd_sel_q[DCR_FIELD_W*ch +: DCR_FIELD_W]),
			.ctl_o(ctl_d[ch])
		);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				code_q[i] <= CODE_MID;
			end
			ref_sel_q <= DCR_RST_REF_SEL[SEL_W-1:0];
			pd_sel_q <= DCR_RST_PWR_DOWN[SEL_W-1:0];
			rsp_q <= '0;
			// Supply reference, normal output: what the reset fields decode to
			for (int i = 0; i < NUM_CH; i++) begin
				ctl_q[i] <= '{ref_src: DCR_SRC_VDD, ref_buf_en: 1'b0, out_active: 1'b1, out_load: DCR_LOAD_NONE};
			end
		end else begin
			code_q <= code_d;
			ref_sel_q <= ref_sel_d;
			pd_sel_q <= pd_sel_d;
			rsp_q <= rsp_d;
			ctl_q <= ctl_d;
		end
	end

	// Ladder code and raw fields come straight from the storage flops
	assign ladder_code_o = code_q;
	assign ref_sel_o = ref_sel_q;
	assign pd_sel_o = pd_sel_q;
	assign ch_ctl_o = ctl_q;
	assign rsp_o = rsp_q;

endmodule

// *** sim/dcr_reg_bank_chk.sv ***
// Port assertions for the register bank
`timescale 1ns/10ps
module dcr_reg_bank_chk import dcr_pkg::*; #(
	parameter int RES_BITS = 12,
	parameter int NUM_CH = 2
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input dcr_req_type req_i,
	input dcr_rsp_type rsp_o,
	input wire logic [NUM_CH-1:0][RES_BITS-1:0] ladder_code_o,
	input wire logic [2*NUM_CH-1:0] ref_sel_o,
	input wire logic [2*NUM_CH-1:0] pd_sel_o,
	input dcr_ch_ctl_type [NUM_CH-1:0] ch_ctl_o
);
	logic tk, mp, rdo;
	logic [4:0] a;
	assign a = req_i.addr;
	assign tk = req_i.wr | req_i.rd;
	assign rdo = req_i.rd & ~req_i.wr;
	assign mp = a == 5'h00 || a == 5'h08 || a == 5'h09 || (a == 5'h01 && NUM_CH == 2);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_rsp_next: assert property (tk |=> rsp_o.valid) else $error("no answer");
	a_rsp_idle: assert property (!tk |=> !rsp_o.valid) else $error("stray answer");
	a_err_unmap: assert property (rdo && !mp
		|=> rsp_o.err && rsp_o.rdata == 16'((1 << RES_BITS) - 1)) else $error("unmapped read");
	a_code_wr: assert property (req_i.wr && a == 5'h00
		|=> ladder_code_o[0] == $past(req_i.wdata[RES_BITS-1:0])) else $error("code write");
	a_ref_wr: assert property (req_i.wr && a == 5'h08
		|=> ref_sel_o == $past(req_i.wdata[2*NUM_CH-1:0])) else $error("ref write");
	a_pd_wr: assert property (req_i.wr && a == 5'h09
		|=> pd_sel_o == $past(req_i.wdata[2*NUM_CH-1:0])) else $error("pd write");
	a_ref_rd: assert property (rdo && a == 5'h08
		|=> rsp_o.rdata == 16'(ref_sel_o)) else $error("ref read");
	a_code_rd: assert property (rdo && a == 5'h00
		|=> rsp_o.rdata == 16'(ladder_code_o[0])) else $error("code read");
	// Guard on the previous reset so the lag check never looks across a reset edge
	a_ctl_lag: assert property ($past(rst_n_i) |-> ch_ctl_o[0].ref_buf_en == $past(ref_sel_o[0])
		&& ch_ctl_o[0].out_active == ($past(pd_sel_o[1:0]) == 2'h0)) else $error("ctl lag");
	c_code_wr: cover property (req_i.wr && a == 5'h00);
	c_unmap: cover property (rdo && !mp);
	c_pin_buf: cover property (ch_ctl_o[0].ref_src == DCR_SRC_PIN && ch_ctl_o[0].ref_buf_en);
endmodule

// *** sim/dcr_host_bfm.sv ***
// Register master model issuing single-word accesses
`timescale 1ns/10ps
module dcr_host_bfm import dcr_pkg::*; (
	input wire logic clk_sys_i,
	output dcr_req_type req_o,
	input dcr_rsp_type rsp_i
);
	initial req_o = '0;
	task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d, output dcr_rsp_type r);
		int n;
		@(negedge clk_sys_i);
		req_o = '{w, !w, a, d};
		@(negedge clk_sys_i);
		// Released lines carry the inverse so no stale value can pass
		req_o = '{1'b0, 1'b0, ~a, ~d};
		for (n = 0; n < 4 && rsp_i.valid !== 1'b1; n++) begin
			@(negedge clk_sys_i);
		end
		r = rsp_i;
	endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the register bank
`timescale 1ns/10ps
module tb;
	import dcr_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	dcr_req_type req;
	dcr_rsp_type rsp, r;
	logic [1:0][11:0] code;
	logic [3:0] rsel, psel;
	dcr_ch_ctl_type [1:0] ctl;
	int mismatches = 0;
	int n_checks = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	dcr_reg_bank #(.RES_BITS(12), .NUM_CH(2)) dcr_reg_bank_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.req_i(req), .rsp_o(rsp), .ladder_code_o(code), .ref_sel_o(rsel), .pd_sel_o(psel), .ch_ctl_o(ctl));
	dcr_host_bfm dcr_host_bfm_i (.clk_sys_i(clk_sys_i), .req_o(req), .rsp_i(rsp));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, input logic e, input logic [15:0] q);
		dcr_host_bfm_i.access(w, a, d, r);
		chk("valid", 16'(r.valid), 16'h1);
		chk("err", 16'(r.err), 16'(e));
		if (!w) chk("rdata", r.rdata, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] q);
		acc(1'b0, a, 16'h0, 1'b0, q);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		acc(1'b1, a, d, 1'b0, 16'h0);
	endtask
	task automatic t_reset;
		rd(DCR_OFS_CODE_CH0, 16'h07ff);
		rd(DCR_OFS_CODE_CH1, 16'h07ff);
		rd(DCR_OFS_REF_SEL, 16'h0000);
		rd(DCR_OFS_PWR_DOWN, 16'h0000);
	endtask
	task automatic t_code;
		wr(DCR_OFS_CODE_CH0, 16'hffff);
		wr(DCR_OFS_CODE_CH1, 16'hf000);
		rd(DCR_OFS_CODE_CH0, 16'h0fff);
		rd(DCR_OFS_CODE_CH1, 16'h0000);
		chk("code0", 16'(code[0]), 16'h0fff);
		chk("code1", 16'(code[1]), 16'h0000);
	endtask
	task automatic t_sel;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr(DCR_OFS_REF_SEL, {12'hfff, ~c, c});
			// Pass 0 pairs supply reference with an open output on channel 0
			wr(DCR_OFS_PWR_DOWN, {12'hfff, c, ~c});
			rd(DCR_OFS_REF_SEL, {12'h0, ~c, c});
			rd(DCR_OFS_PWR_DOWN, {12'h0, c, ~c});
			chk("rsel", 16'(rsel), {12'h0, ~c, c});
			chk("psel", 16'(psel), {12'h0, c, ~c});
			chk("src0", 16'(ctl[0].ref_src), 16'(c == 2'h0 ? DCR_SRC_VDD : c == 2'h1 ? DCR_SRC_BANDGAP : DCR_SRC_PIN));
			chk("buf1", 16'(ctl[1].ref_buf_en), {15'h0, ~c[0]});
			chk("load0", 16'(ctl[0].out_load), {14'h0, ~c});
			chk("act1", 16'(ctl[1].out_active), 16'(c == 2'h0));
		end
	endtask
	task automatic t_bad;
		acc(1'b1, 5'h02, 16'h0123, 1'b1, 16'h0);
		acc(1'b0, 5'h0a, 16'h0, 1'b1, 16'h0fff);
		acc(1'b0, 5'h1f, 16'h0, 1'b1, 16'h0fff);
		rd(DCR_OFS_CODE_CH0, 16'h0fff);
	endtask
	task automatic stop_test;
		$display("mismatches %0d checks %0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		t_reset;
		t_code;
		t_sel;
		t_bad;
		stop_test;
	end
endmodule
bind dcr_reg_bank dcr_reg_bank_chk #(.RES_BITS(RES_BITS), .NUM_CH(NUM_CH)) dcr_reg_bank_chk_i (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req_i), .rsp_o(rsp_o), .ladder_code_o(ladder_code_o),
	.ref_sel_o(ref_sel_o), .pd_sel_o(pd_sel_o), .ch_ctl_o(ch_ctl_o)
);
